// *** tsr_defs.svh ***
// constants and register map of the target/slew ramp engine
// Contract
// - hold: control bit 9 low, bit 6 high
// - bit 7 clears memory, self-clears, 100 us
// - bit 12 ramps volume down, bit 13 done
// - clearing bit 12 ramps volume back up
// - 64 slew locations, each with a target
// - new target starts ramp, one step per frame
// - 34-bit target: 6 control, 28 data bits
// - constant time: 2.14 target in bits 27 to 12
// - mute forces targets zero, release restores
// - type 00 lin, 01 dB, 10 RC, 11 time
// - linear: fixed step from time constant table
// - constant dB: step from current slew value
// - RC: step from target minus slew
// - constant time: step = difference / step count
// - mute leaves constant time locations alone
// - 4-bit time constant, 0000 fastest
// - refresh flag recomputes step, then clears itself
// - step count is 2 to (code plus 6)
// - reset: linear, constant 5, data and slew 1.0
// - staged target write lands within one frame
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
`define TSR_OFF_CTRL      8'h00
`define TSR_OFF_TGT_LO    8'h04
`define TSR_OFF_TGT_CMD   8'h08
`define TSR_OFF_SLEW_SEL  8'h0c
`define TSR_OFF_SLEW_VAL  8'h10
`define TSR_CTRL_HOLD     6
`define TSR_CTRL_CLR      7
`define TSR_CTRL_RUN_N    9
`define TSR_CTRL_RDN      12
`define TSR_CTRL_DONE     13
`define TSR_CTRL_MUTE     14
`define TSR_CMD_TYPE_HI   9
`define TSR_CMD_TYPE_LO   8
`define TSR_TYPE_HI       33
`define TSR_TYPE_LO       32
`define TSR_TC_HI         31
`define TSR_TC_LO         28
`define TSR_UPD_BIT       31
`define TSR_NSTEP_HI      30
`define TSR_NSTEP_LO      28
`define TSR_CT_HI         27
`define TSR_CT_LO         12
`define TSR_DATA_HI       27
`define TSR_NLOC          64
`define TSR_TGT_RST       34'h0_5080_0000
`define TSR_SLEW_RST      28'h080_0000
`define TSR_NSTEP_BASE    5'h06
`define TSR_EXP_SH_BASE   5'h02
`define TSR_CLK_NS        10
`define TSR_MEMCLR_US     100
`define TSR_MEMCLR_CYC    ((`TSR_MEMCLR_US * 1000 + `TSR_CLK_NS - 1) / `TSR_CLK_NS)
`define TSR_WALK_LAST     6'h3f
`endif

// *** tsr_pkg.sv ***
// types shared by the target/slew ramp engine
package tsr_pkg;
  typedef enum logic [1:0] {
    RAMP_LIN   = 2'b00,
    RAMP_CDB   = 2'b01,
    RAMP_RC    = 2'b10,
    RAMP_CTIME = 2'b11
  } tsr_ramp_t;
  typedef enum logic {
    WALK_IDLE = 1'b0,
    WALK_RUN  = 1'b1
  } tsr_walk_t;
endpackage

// *** tsr_engine.sv ***
// target/slew ramp engine with AHB-Lite register slave
`timescale 1ns/1ns
`include "tsr_defs.svh"
module tsr_engine
  import tsr_pkg::*;
#(
  parameter int unsigned MEMCLR_CYC = `TSR_MEMCLR_CYC
)(
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        lrclk_i,
  input  wire logic [5:0]  coef_idx_i,
  output logic      [27:0] coef_o,
  output logic             core_hold_o,
  output logic             mem_clear_o,
  output logic             ramp_done_o
);

  // linear step per frame in 5.23 lsbs, 2^13 * 10^(-(tc-5)/10)
  function automatic logic [28:0] lin_step(input logic [3:0] tc);
    case (tc)
      4'h0: lin_step = 29'h0006531;
      4'h1: lin_step = 29'h0005061;
      4'h2: lin_step = 29'h0003fd9;
      4'h3: lin_step = 29'h00032b7;
      4'h4: lin_step = 29'h0002849;
      4'h5: lin_step = 29'h0002000;
      4'h6: lin_step = 29'h000196b;
      4'h7: lin_step = 29'h0001431;
      4'h8: lin_step = 29'h000100a;
      4'h9: lin_step = 29'h0000cbd;
      4'ha: lin_step = 29'h0000a1f;
      4'hb: lin_step = 29'h000080a;
      4'hc: lin_step = 29'h0000663;
      4'hd: lin_step = 29'h0000512;
      4'he: lin_step = 29'h0000407;
      default: lin_step = 29'h0000333;
    endcase
  endfunction

  function automatic logic [28:0] mag29(input logic signed [28:0] v);
    mag29 = v[28] ? 29'(-v) : 29'(v);
  endfunction

  function automatic logic signed [28:0] sx29(input logic [27:0] v);
    sx29 = $signed({v[27], v});
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------- bus slave ----------------
  logic        addr_ph;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  wr_addr_r;
  logic [7:0]  rd_addr_r;
  logic [31:0] hrdata_r;
  logic        hready_r;
  logic        hold_r;
  logic        run_n_r;
  logic        clr_r;
  logic        rdn_r;
  logic        done_r;
  logic        mute_r;
  logic [31:0] tgt_lo_r;
  logic [5:0]  sel_r;
  logic        tgt_wr;
  logic [5:0]  tgt_wr_idx;
  logic [33:0] tgt_wr_val;
  logic        ctrl_wr;

  assign addr_ph = hsel_i && htrans_i[1] && hready_i;
  assign ctrl_wr = wr_pend_r && hit(wr_addr_r, `TSR_OFF_CTRL);
  assign tgt_wr  = wr_pend_r && hit(wr_addr_r, `TSR_OFF_TGT_CMD);
  assign tgt_wr_idx = hwdata_i[5:0];
  assign tgt_wr_val = {hwdata_i[`TSR_CMD_TYPE_HI:`TSR_CMD_TYPE_LO],
                       tgt_lo_r};

  logic [27:0] slew_rd;
  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input logic [27:0] sv);
    rd_word = '0;
    if (hit(a, `TSR_OFF_CTRL)) begin
      rd_word[`TSR_CTRL_HOLD]  = hold_r;
      rd_word[`TSR_CTRL_CLR]   = clr_r;
      rd_word[`TSR_CTRL_RUN_N] = run_n_r;
      rd_word[`TSR_CTRL_RDN]   = rdn_r;
      rd_word[`TSR_CTRL_DONE]  = done_r;
      rd_word[`TSR_CTRL_MUTE]  = mute_r;
    end else if (hit(a, `TSR_OFF_TGT_LO)) begin
      rd_word = tgt_lo_r;
    end else if (hit(a, `TSR_OFF_SLEW_SEL)) begin
      rd_word = {26'h0, sel_r};
    end else if (hit(a, `TSR_OFF_SLEW_VAL)) begin
      rd_word = {{4{sv[27]}}, sv};
    end
  endfunction

  // reads take one wait state so a write just before is always seen
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      hready_r  <= 1'b1;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ph && hwrite_i;
      rd_pend_r <= addr_ph && !hwrite_i;
      if (addr_ph) begin
        wr_addr_r <= haddr_i[7:0];
        rd_addr_r <= haddr_i[7:0];
      end
      if (addr_ph && !hwrite_i) begin
        hready_r <= 1'b0;
      end else if (rd_pend_r) begin
        hready_r <= 1'b1;
        hrdata_r <= rd_word(rd_addr_r, slew_rd);
      end
    end
  end

  assign hrdata_o    = hrdata_r;
  assign hreadyout_o = hready_r;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tgt_lo_r <= 32'h0000_0000;
      sel_r    <= 6'h00;
    end else if (wr_pend_r) begin
      if (hit(wr_addr_r, `TSR_OFF_TGT_LO)) begin
        tgt_lo_r <= hwdata_i;
      end
      if (hit(wr_addr_r, `TSR_OFF_SLEW_SEL)) begin
        sel_r <= hwdata_i[5:0];
      end
    end
  end

  // ---------------- core control ----------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hold_r  <= 1'b0;
      run_n_r <= 1'b0;
      rdn_r   <= 1'b0;
      mute_r  <= 1'b0;
    end else if (ctrl_wr) begin
      hold_r  <= hwdata_i[`TSR_CTRL_HOLD];
      run_n_r <= hwdata_i[`TSR_CTRL_RUN_N];
      rdn_r   <= hwdata_i[`TSR_CTRL_RDN];
      mute_r  <= hwdata_i[`TSR_CTRL_MUTE];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      core_hold_o <= 1'b1;
    end else begin
      core_hold_o <= !run_n_r || hold_r;
    end
  end

  logic [31:0] clr_cnt_r;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      clr_r     <= 1'b0;
      clr_cnt_r <= 32'h0;
    end else if (!clr_r) begin
      if (ctrl_wr && hwdata_i[`TSR_CTRL_CLR]) begin
        clr_r     <= 1'b1;
        clr_cnt_r <= 32'(MEMCLR_CYC - 1);
      end
    end else if (clr_cnt_r == 32'h0) begin
      clr_r <= 1'b0;
    end else begin
      clr_cnt_r <= clr_cnt_r - 32'h1;
    end
  end
  assign mem_clear_o = clr_r;

  memclr_len_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $rose(clr_r) |-> clr_cnt_r == 32'(MEMCLR_CYC - 1))
    else $error("memory clear length wrong");

  memclr_end_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    clr_r && clr_cnt_r == 32'h0 |=> !clr_r && !mem_clear_o)
    else $error("memory clear bit not released");

  hold_out_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ##1 core_hold_o == ($past(!run_n_r) || $past(hold_r)))
    else $error("core hold output wrong");

  // ---------------- frame timing ----------------
  logic lr_s1_r;
  logic lr_s2_r;
  logic lr_s3_r;
  logic frame_tick;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      lr_s1_r <= 1'b0;
      lr_s2_r <= 1'b0;
      lr_s3_r <= 1'b0;
    end else begin
      lr_s1_r <= lrclk_i;
      lr_s2_r <= lr_s1_r;
      lr_s3_r <= lr_s2_r;
    end
  end
  assign frame_tick = lr_s2_r && !lr_s3_r;

  // ---------------- ramp memories ----------------
  logic        [33:0] tgt_r  [0:`TSR_NLOC-1];
  logic signed [27:0] slew_r [0:`TSR_NLOC-1];
  logic signed [27:0] step_r [0:`TSR_NLOC-1];

  tsr_walk_t walk_r;
  logic [5:0] idx_r;
  logic       all_zero_r;
  logic       walking;
  assign walking = (walk_r == WALK_RUN);
  assign slew_rd = slew_r[sel_r];

  // one location per cycle, 64 cycles once per frame
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      walk_r <= WALK_IDLE;
      idx_r  <= 6'h00;
    end else begin
      case (walk_r)
        WALK_IDLE: begin
          if (frame_tick) begin
            walk_r <= WALK_RUN;
            idx_r  <= 6'h00;
          end
        end
        WALK_RUN: begin
          idx_r <= idx_r + 6'h01;
          if (idx_r == `TSR_WALK_LAST) begin
            walk_r <= WALK_IDLE;
          end
        end
        default: walk_r <= WALK_IDLE;
      endcase
    end
  end

  // ---------------- per-location arithmetic ----------------
  logic        [33:0] cur_t;
  logic signed [27:0] cur;
  tsr_ramp_t          rtype;
  logic               is_ct;
  logic               upd;
  logic signed [27:0] tgt_d;
  logic signed [27:0] eff_tgt;
  logic signed [28:0] diff;
  logic        [28:0] adiff;
  logic        [4:0]  sh;
  logic signed [28:0] ct_new;
  logic        [28:0] mag;
  logic signed [27:0] nxt;

  always_comb begin
    cur_t = tgt_r[idx_r];
    cur   = slew_r[idx_r];
    rtype = tsr_ramp_t'(cur_t[`TSR_TYPE_HI:`TSR_TYPE_LO]);
    is_ct = (rtype == RAMP_CTIME);
    upd   = is_ct && cur_t[`TSR_UPD_BIT];
    // 2.14 widened to 5.23
    tgt_d = is_ct ? $signed({{3{cur_t[`TSR_CT_HI]}},
                     cur_t[`TSR_CT_HI:`TSR_CT_LO], 9'h000})
                  : $signed(cur_t[`TSR_DATA_HI:0]);
    eff_tgt = ((mute_r || rdn_r) && !is_ct) ? 28'sh0 : tgt_d;
    diff  = sx29(eff_tgt) - sx29(cur);
    adiff = mag29(diff);
    sh    = {1'b0, cur_t[`TSR_TC_HI:`TSR_TC_LO]} + `TSR_EXP_SH_BASE;
    ct_new = diff >>> ({2'b00, cur_t[`TSR_NSTEP_HI:`TSR_NSTEP_LO]}
                       + `TSR_NSTEP_BASE);
    case (rtype)
      RAMP_LIN: mag = lin_step(cur_t[`TSR_TC_HI:`TSR_TC_LO]);
      RAMP_CDB: mag = mag29(sx29(cur)) >> sh;
      RAMP_RC:  mag = adiff >> sh;
      RAMP_CTIME: begin
        mag = upd ? mag29(ct_new) : mag29(sx29(step_r[idx_r]));
      end
      default: mag = adiff;
    endcase
    if (mag == 29'h0) begin
      mag = 29'h1;
    end
    if (mag >= adiff) begin
      nxt = eff_tgt;
    end else if (diff > 29'sh0) begin
      nxt = cur + $signed(mag[27:0]);
    end else begin
      nxt = cur - $signed(mag[27:0]);
    end
  end

  // target words: host write wins over the flag clear on the same word
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < `TSR_NLOC; i++) begin
        tgt_r[i] <= `TSR_TGT_RST;
      end
    end else begin
      if (walking && upd) begin
        tgt_r[idx_r][`TSR_UPD_BIT] <= 1'b0;
      end
      if (tgt_wr) begin
        tgt_r[tgt_wr_idx] <= tgt_wr_val;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < `TSR_NLOC; i++) begin
        slew_r[i] <= `TSR_SLEW_RST;
        step_r[i] <= 28'sh0;
      end
    end else if (walking) begin
      slew_r[idx_r] <= nxt;
      if (upd) begin
        step_r[idx_r] <= ct_new[27:0];
      end
    end
  end

  // ramp-down completes once a whole frame sees every non-constant-time volume at zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      all_zero_r <= 1'b1;
      done_r     <= 1'b0;
    end else begin
      if (!rdn_r) begin
        done_r <= 1'b0;
      end
      if (frame_tick && !walking) begin
        all_zero_r <= 1'b1;
      end else if (walking) begin
        if (!is_ct && nxt != 28'sh0) begin
          all_zero_r <= 1'b0;
        end
        if (idx_r == `TSR_WALK_LAST) begin
          done_r <= rdn_r && all_zero_r && (is_ct || nxt == 28'sh0);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ramp_done_o <= 1'b0;
      coef_o      <= 28'h0;
    end else begin
      ramp_done_o <= done_r;
      coef_o      <= slew_r[coef_idx_i];
    end
  end

  // ---------------- checks ----------------
  walk_len_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    frame_tick && !walking |=> walking [*8] ##57 !walking)
    else $error("frame walk not 64 cycles");

  no_overshoot_a: assert property (@(posedge sys_clk_i)
    disable iff (srst_i)
    walking && diff > 29'sh0 |-> nxt <= eff_tgt && nxt > cur)
    else $error("slew overshoot on rising ramp");

  no_undershoot_a: assert property (@(posedge sys_clk_i)
    disable iff (srst_i)
    walking && diff < 29'sh0 |-> nxt >= eff_tgt && nxt < cur)
    else $error("slew overshoot on falling ramp");

  mute_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    walking && mute_r |-> (is_ct ? eff_tgt == tgt_d
                                 : eff_tgt == 28'sh0))
    else $error("mute target wrong");

  flag_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    walking && upd && !(tgt_wr && tgt_wr_idx == idx_r)
    |=> !tgt_r[$past(idx_r)][`TSR_UPD_BIT])
    else $error("step refresh flag not cleared");

  tgt_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    tgt_wr |=> tgt_r[$past(tgt_wr_idx)] == $past(tgt_wr_val))
    else $error("target write lost");

  done_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ramp_done_o |-> $past(rdn_r) || $past(rdn_r, 2))
    else $error("ramp done without ramp down");

  reset_val_a: assert property (@(posedge sys_clk_i)
    $fell(srst_i) |-> slew_r[0] == `TSR_SLEW_RST
                   && tgt_r[63] == `TSR_TGT_RST)
    else $error("reset values wrong");

  bus_okay_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rd_pend_r |-> !hreadyout_o ##1 hreadyout_o && !hresp_o)
    else $error("read wait state wrong");

endmodule

// *** tsr_host.sv ***
// host controller model: AHB-Lite master doing single word transfers
`timescale 1ns/1ns
module tsr_host (
  input  wire logic        sys_clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic      [31:0] haddr_o,
  output logic      [1:0]  htrans_o,
  output logic             hwrite_o,
  output logic      [2:0]  hsize_o,
  output logic      [31:0] hwdata_o
);
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o  = 3'b010;
    hwdata_o = 32'h0;
  end

  // single reads and writes; callers keep hold, clear, release, fill order
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic ok);
    int n;
    n  = 0;
    ok = 1'b1;
    @(posedge sys_clk_i);
    hsel_o   <= 1'b1;
    haddr_o  <= a;
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o  <= 3'b010;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1 && n < 16) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (hready_i !== 1'b1)
      ok = 1'b0;
    hsel_o   <= 1'b0;
    htrans_o <= 2'b00;
    haddr_o  <= ~a;
    // unused upper and reserved bits are sent as zero by callers, except the all-ones write to offset 0x14
    hwdata_o <= wr ? d : ~hwdata_o;
    n = 0;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1 && n < 16) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (hready_i !== 1'b1)
      ok = 1'b0;
    q = hrdata_i;
    // released data bus must not keep showing the last word
    hwdata_o <= ~hwdata_o;
  endtask
endmodule

// *** target_slew_ramp_engine_bench.sv ***
// self-checking bench for the target/slew ramp engine
`timescale 1ns/1ns
`include "tsr_defs.svh"
module target_slew_ramp_engine_bench;
  localparam int MCLR = 20;
  logic        sys_clk_i;
  logic        srst_i;
  logic        lrclk_i;
  logic [7:0]  fcnt;
  logic [5:0]  coef_idx_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [27:0] coef_o;
  logic        core_hold_o;
  logic        mem_clear_o;
  logic        ramp_done_o;
  int          failures;
  int          num_checks;
  logic [5:0]  t_idx [9] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
                             6'h09, 6'h0a, 6'h0b};
  logic [1:0]  t_ty [9] = '{2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h1,
                            2'h0, 2'h0};
  logic [31:0] t_lo [9] = '{32'h507fd000, 32'h80000000, 32'h90000000,
                            32'ha0000000, 32'hb0000000, 32'h01000000,
                            32'h01000000, 32'hf0000000, 32'h00000000};
  // tc 0 linear step is 0x6531 lsbs: 1.0 falls to 0x7f9acf, then 0x7f359e
  logic [27:0] t_e1 [9] = '{28'h7fe000, 28'h7e0000, 28'h7f0000, 28'h7f8000,
                            28'h7fc000, 28'ha00000, 28'ha00000, 28'h7ffccd,
                            28'h7f9acf};
  logic [27:0] t_e2 [9] = '{28'h7fd000, 28'h7c0000, 28'h7e0000, 28'h7f0000,
                            28'h7f8000, 28'hb80000, 28'hc80000, 28'h7ff99a,
                            28'h7f359e};

  tsr_engine #(.MEMCLR_CYC(MCLR)) i_dut (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .hsel_i      (hsel),
    .haddr_i     (haddr),
    .htrans_i    (htrans),
    .hwrite_i    (hwrite),
    .hsize_i     (hsize),
    .hready_i    (hready),
    .hwdata_i    (hwdata),
    .hrdata_o    (hrdata),
    .hreadyout_o (hready),
    .hresp_o     (hresp),
    .lrclk_i     (lrclk_i),
    .coef_idx_i  (coef_idx_i),
    .coef_o      (coef_o),
    .core_hold_o (core_hold_o),
    .mem_clear_o (mem_clear_o),
    .ramp_done_o (ramp_done_o)
  );

  tsr_host i_host (
    .sys_clk_i (sys_clk_i),
    .hready_i  (hready),
    .hrdata_i  (hrdata),
    .hsel_o    (hsel),
    .haddr_o   (haddr),
    .htrans_o  (htrans),
    .hwrite_o  (hwrite),
    .hsize_o   (hsize),
    .hwdata_o  (hwdata)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // frame every 256 clocks leaves room for setup between walks
  always @(posedge sys_clk_i) begin
    fcnt    <= fcnt + 8'h01;
    lrclk_i <= fcnt[7];
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic hang();
    failures++;
    $display("[FAIL] %0t ns: wait ran out", $time);
    results();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        ok;
    i_host.xfer(1'b1, {24'h0, a}, d, q, ok);
    if (!ok)
      hang();
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        ok;
    i_host.xfer(1'b0, {24'h0, a}, 32'h0, q, ok);
    if (!ok)
      hang();
    chk(q, exp);
  endtask

  task automatic slew(input logic [5:0] i, input logic [31:0] exp);
    wr(`TSR_OFF_SLEW_SEL, {26'h0, i});
    rdc(`TSR_OFF_SLEW_VAL, exp);
  endtask

  task automatic tgt(input logic [5:0] i, input logic [1:0] ty,
                     input logic [31:0] lo);
    wr(`TSR_OFF_TGT_LO, lo);
    wr(`TSR_OFF_TGT_CMD, {22'h0, ty, 2'b00, i});
  endtask

  task automatic wait_cnt(input logic [7:0] v);
    int n;
    n = 0;
    while (fcnt !== v && n < 300) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 300)
      hang();
  endtask

  // returns once this frame's walk has surely finished
  task automatic frames(input int n);
    repeat (n) begin
      wait_cnt(8'h80);
      wait_cnt(8'hd2);
    end
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    hang();
  end

  initial begin
    int n;
    srst_i     = 1'b1;
    coef_idx_i = 6'h03;
    fcnt       = 8'h00;
    lrclk_i    = 1'b0;
    failures   = 0;
    num_checks = 0;
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk({31'h0, core_hold_o}, 32'h1);
    rdc(`TSR_OFF_CTRL, 32'h0);
    slew(6'h00, 32'h00800000);
    slew(6'h3f, 32'h00800000);
    chk({4'h0, coef_o}, 32'h00800000);
    rdc(8'h14, 32'h0);
    wr(8'h14, 32'hffffffff);
    rdc(8'h14, 32'h0);
    rdc(`TSR_OFF_TGT_CMD, 32'h0);
    $display("test reset and map done");
    wr(`TSR_OFF_CTRL, 32'h00000240);
    repeat (3) @(posedge sys_clk_i);
    chk({31'h0, core_hold_o}, 32'h1);
    wr(`TSR_OFF_CTRL, 32'h000002c0);
    n = 0;
    while (mem_clear_o !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      n++;
    end
    n = 0;
    while (mem_clear_o === 1'b1 && n < 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk(n, MCLR);
    rdc(`TSR_OFF_CTRL, 32'h00000240);
    wr(`TSR_OFF_CTRL, 32'h00000200);
    repeat (3) @(posedge sys_clk_i);
    chk({31'h0, core_hold_o}, 32'h0);
    $display("test hold and clear done");
    wait_cnt(8'hd2);
    for (int k = 0; k < 9; k++)
      tgt(t_idx[k], t_ty[k], t_lo[k]);
    frames(1);
    for (int k = 0; k < 9; k++)
      slew(t_idx[k], {4'h0, t_e1[k]});
    frames(1);
    for (int k = 0; k < 9; k++)
      slew(t_idx[k], {4'h0, t_e2[k]});
    chk({4'h0, coef_o}, 32'h007fd000);
    frames(1);
    slew(6'h03, 32'h007fd000);
    slew(6'h04, 32'h007a0000);
    $display("test ramp curves done");
    wr(`TSR_OFF_CTRL, 32'h00004200);
    frames(1);
    slew(6'h03, 32'h007fb000);
    slew(6'h04, 32'h00780000);
    wr(`TSR_OFF_CTRL, 32'h00000200);
    frames(1);
    slew(6'h03, 32'h007fd000);
    slew(6'h04, 32'h00760000);
    $display("test mute done");
    for (int k = 0; k < 64; k++)
      tgt(k[5:0], 2'b10, 32'h00800000);
    wr(`TSR_OFF_CTRL, 32'h00001200);
    frames(1);
    chk({31'h0, ramp_done_o}, 32'h0);
    n = 0;
    while (ramp_done_o !== 1'b1 && n < 150) begin
      frames(1);
      n++;
    end
    if (n >= 150)
      hang();
    rdc(`TSR_OFF_CTRL, 32'h00003200);
    slew(6'h00, 32'h0);
    wr(`TSR_OFF_CTRL, 32'h00000200);
    repeat (3) @(posedge sys_clk_i);
    chk({31'h0, ramp_done_o}, 32'h0);
    frames(1);
    slew(6'h00, 32'h00200000);
    $display("test volume ramp done");
    results();
  end
endmodule
